// ==== tb/efs_e1_src.sv ====
// far-end e1 source: framed stream, crc and signalling multiframe content
`timescale 1ns/100ps

module efs_e1_src (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic fas_on_i, // send alignment words
	input wire logic crc_on_i, // send crc multiframe bits
	input wire logic bad_fas_i, // corrupt alignment words
	input wire logic bad_mf_i, // invert first multiframe bit
	output logic rx_bit_o, // line bit
	output logic rx_bit_en_o, // line strobe
	output logic [3:0] frm_o // frame number
);
	// frames 1..11 carry 001011, e bits in 13 and 15 report no error
	localparam logic [15:0] SI_ODD = 16'hAA20;
	logic [7:0] bit_reg, bit_next, byte_v;
	logic [3:0] frm_next;
	logic si, out_next;

	always_comb begin
		si = frm_o[0] ? (SI_ODD[frm_o] ^ (bad_mf_i && frm_o == 4'h1)) : ~frm_o[1];
		if (!crc_on_i) begin
			si = 1'b1;
		end
		// idle bytes are all ones so no false alignment word appears
		byte_v = 8'hFF;
		if (bit_reg[7:3] == 5'h00 && fas_on_i) begin
			byte_v = frm_o[0] ? {si, 7'h76} : {si, bad_fas_i ? 7'h00 : 7'h1B};
		end
		if (bit_reg[7:3] == 5'h10) begin
			byte_v = (frm_o == 4'h0) ? 8'h0F : 8'h55;
		end
		bit_next = bit_reg + 8'h01;
		frm_next = (bit_reg == 8'hFF) ? frm_o + 4'h1 : frm_o;
		out_next = byte_v[~bit_reg[2:0]];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_reg <= 8'h00;
			frm_o <= 4'h0;
			rx_bit_o <= 1'b1;
			rx_bit_en_o <= 1'b0;
		end else begin
			bit_reg <= bit_next;
			frm_o <= frm_next;
			rx_bit_o <= out_next;
			rx_bit_en_o <= 1'b1;
		end
	end
endmodule

// ==== tb/efs_frame_sync_props.sv ====
// concurrent checks on the e1 frame sync ports
`timescale 1ns/100ps

module efs_frame_sync_props #(
	parameter int T8_FRAMES = 64, // crc window
	parameter int T400_FRAMES = 3200, // interworking limit
	parameter int RED_FRAMES = 800 // red alarm delay
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic rx_bit_i, // line bit
	input wire logic rx_bit_en_i, // line strobe
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // acknowledge
	input wire logic ts16_bit_o, // ts16 bit
	input wire logic ts16_en_o, // ts16 strobe
	input wire logic red_alarm_o // red alarm
);
	// one frame of slack: the design counts whole frames, the gap counts bits
	localparam logic [31:0] RED_MIN = 32'((RED_FRAMES - 1) * 256);
	logic [31:0] gap_reg, gap_next;
	logic unfr_reg, unfr_next;

	always_comb begin
		gap_next = gap_reg;
		if (ts16_en_o) begin
			gap_next = 32'h0;
		end else if (rx_bit_en_i && gap_reg != 32'hFFFFFFFF) begin
			gap_next = gap_reg + 32'h1;
		end
		unfr_next = unfr_reg;
		if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) begin
			unfr_next = wb_dat_i[0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_reg <= 32'h0;
			unfr_reg <= 1'b0;
		end else begin
			gap_reg <= gap_next;
			unfr_reg <= unfr_next;
		end
	end

	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
		else $error("read data moved");
	AST_TS16_COPY: assert property (ts16_en_o |-> $past(rx_bit_en_i) && ts16_bit_o == $past(rx_bit_i))
		else $error("ts16 bit not a copy");
	AST_RED_LATE: assert property ($rose(red_alarm_o) |-> gap_reg >= RED_MIN)
		else $error("red alarm early");
	AST_RED_NO_TS16: assert property (red_alarm_o |-> !ts16_en_o)
		else $error("ts16 during red alarm");
	AST_BYPASS: assert property (unfr_reg && $past(unfr_reg) |-> !ts16_en_o)
		else $error("ts16 in bypass");
	AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !ts16_en_o && !red_alarm_o)
		else $error("outputs active in reset");
endmodule

bind efs_frame_sync efs_frame_sync_props #(.T8_FRAMES(T8_FRAMES), .T400_FRAMES(T400_FRAMES),
	.RED_FRAMES(RED_FRAMES)) u_props (.clk_i(clk_i), .rst_i(rst_i), .rx_bit_i(rx_bit_i),
	.rx_bit_en_i(rx_bit_en_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .ts16_bit_o(ts16_bit_o), .ts16_en_o(ts16_en_o), .red_alarm_o(red_alarm_o));

// ==== tb/efs_frame_sync_tb_top.sv ====
// self-checking bench for the e1 frame sync block
`timescale 1ns/100ps
`include "efs_map.svh"

module efs_frame_sync_tb_top;
	localparam int T8 = 64;
	localparam int T400 = 120;
	localparam int RED = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic fas_on = 1'b0;
	logic crc_on = 1'b0;
	logic bad_fas = 1'b0;
	logic bad_mf = 1'b0;
	logic rx_bit_i, rx_bit_en_i, ts16_bit_o, ts16_en_o, red_alarm_o, wb_ack_o, p;
	logic [31:0] wb_dat_o, sink;
	logic [7:0] b;
	logic [3:0] frm, f;
	int n;
	int bad_count = 0;
	int num_checks = 0;

	always #4 clk_i = ~clk_i;

	efs_frame_sync #(.T8_FRAMES(T8), .T400_FRAMES(T400), .RED_FRAMES(RED)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.rx_bit_i(rx_bit_i), .rx_bit_en_i(rx_bit_en_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ts16_bit_o(ts16_bit_o), .ts16_en_o(ts16_en_o), .red_alarm_o(red_alarm_o));
	efs_e1_src src (.clk_i(clk_i), .rst_i(rst_i), .fas_on_i(fas_on), .crc_on_i(crc_on), .bad_fas_i(bad_fas),
		.bad_mf_i(bad_mf), .rx_bit_o(rx_bit_i), .rx_bit_en_o(rx_bit_en_i), .frm_o(frm));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 16);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 16) begin
			chk("wb_ack_o", 32'h0, 32'h1);
			print_verdict();
		end
	endtask

	// reads once per frame until the field matches or the frame budget runs out
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int fr, input string what);
		logic [31:0] q;
		for (int i = 0; i < fr; i++) begin
			wb(a, 1'b0, 32'h0, q);
			if ((q & m) === e) break;
			repeat (256) @(posedge clk_i);
		end
		chk(what, q & m, e);
		if (fr > 1 && (q & m) !== e) print_verdict();
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		poll(`EFS_ADR_CTRL, 32'h3F, 32'h02, 1, "ctrl");
		poll(`EFS_ADR_STAT, 32'hFF, 32'h13, 1, "status");
		poll(`EFS_ADR_OVH, 32'h30, 32'h30, 1, "e bits");
		wb(`EFS_ADR_STAT, 1'b1, 32'h0, sink);
		poll(`EFS_ADR_STAT, 32'hFF, 32'h13, 1, "status ro");
		poll(8'h14, 32'hFFFFFFFF, 32'h0, 1, "unmapped");
		$display("test reset done");
		poll(`EFS_ADR_STAT, 32'h21, 32'h21, RED + 4, "red status");
		chk("red pin", {31'h0, red_alarm_o}, 32'h1);
		$display("test red done");
		wb(`EFS_ADR_CTRL, 1'b1, 32'h06, sink);
		fas_on <= 1'b1;
		crc_on <= 1'b1;
		poll(`EFS_ADR_STAT, 32'h21, 32'h0, 6, "frame found");
		n = 0;
		p = 1'b1;
		while (!(ts16_en_o === 1'b1 && p === 1'b0) && n < 600) begin
			p = ts16_en_o;
			@(posedge clk_i);
			n++;
		end
		if (n >= 600) begin
			chk("ts16_en_o", 32'h0, 32'h1);
			print_verdict();
		end
		f = frm;
		for (int k = 0; k < 8; k++) begin
			b = {b[6:0], ts16_bit_o};
			@(posedge clk_i);
		end
		chk("ts16 byte", {24'h0, b}, (f == 4'h0) ? 32'h0F : 32'h55);
		poll(`EFS_ADR_STAT, 32'hFF, 32'hC0, 80, "mf lock");
		poll(`EFS_ADR_OVH, 32'h3F, 32'h3A, 20, "crc bits");
		poll(`EFS_ADR_NAT, 32'hFFFFF, 32'hB5AD6, 20, "national");
		$display("test lock done");
		wb(`EFS_ADR_EVT, 1'b1, 32'h3F, sink);
		bad_mf <= 1'b1;
		repeat (4096) @(posedge clk_i);
		bad_mf <= 1'b0;
		repeat (4096) @(posedge clk_i);
		poll(`EFS_ADR_EVT, 32'h1F, 32'h1F, 1, "events");
		wb(`EFS_ADR_EVT, 1'b1, 32'h01, sink);
		poll(`EFS_ADR_EVT, 32'h01, 32'h0, 1, "event clear");
		poll(`EFS_ADR_STAT, 32'h03, 32'h0, 1, "still locked");
		$display("test pattern error done");
		bad_fas <= 1'b1;
		repeat (1536) @(posedge clk_i);
		bad_fas <= 1'b0;
		crc_on <= 1'b0;
		repeat (256) @(posedge clk_i);
		poll(`EFS_ADR_STAT, 32'h03, 32'h03, 1, "frame lost");
		poll(`EFS_ADR_STAT, 32'h01, 32'h0, 6, "regained");
		poll(`EFS_ADR_STAT, 32'h04, 32'h04, T8 + 8, "offline hunt");
		poll(`EFS_ADR_STAT, 32'h0A, 32'h0A, T400, "interworking");
		$display("test interworking done");
		wb(`EFS_ADR_CTRL, 1'b1, 32'h01, sink);
		poll(`EFS_ADR_STAT, 32'h1F, 32'h13, 1, "bypass");
		repeat (512) @(posedge clk_i);
		chk("red bypass", {31'h0, red_alarm_o}, 32'h0);
		$display("test bypass done");
		print_verdict();
	end
endmodule

// ==== verilog/efs_frame_sync.sv ====
// e1 receive frame, crc multiframe and signalling multiframe alignment with a wishbone register port
//
// Overview of operation
// - search basic, crc and signalling multiframe alignment
// - acquire on alignment, non-alignment, alignment word sequence
// - step two fail skips frame; step three restarts
// - clear out-of-frame status on alignment found
// - crc multiframe is 16 frames, two halves
// - even-frame first bits are crc bits, msb first
// - first six odd first bits match 001011
// - frames 13 and 15 carry far-end error bits
// - remote alarm bit 3; signalling alarm bit 6
// - alarm indications debounced over 1 or 4
// - red alarm after 100 ms out of frame
// - events on frame boundaries and status changes
// - unframed bypass disables all frame processing
// - national codeword refreshed every sub-multiframe
// - timeslot sixteen content driven on own pin
// - crc enabled: start 8 and 400 ms timers
// - two sequences, 2 ms multiples, within 8 ms
// - mismatching sequence after lock sets error flag
// - 8 ms failure starts parallel offline hunt
// - offline alignment restarts 8 ms check
// - 400 ms expiry sets interworking status
// - interworking search continues only when enabled
// - signalling lock on zero nibble after nonzero nibble
// - three word errors lose basic frame alignment
`timescale 1ns/100ps
`include "efs_map.svh"

module efs_frame_sync #(
	parameter int T8_FRAMES = (`EFS_T8_MS * 1000) / `EFS_FRAME_US,
	parameter int T400_FRAMES = (`EFS_T400_MS * 1000) / `EFS_FRAME_US,
	parameter int RED_FRAMES = (`EFS_RED_MS * 1000 + `EFS_FRAME_US - 1) / `EFS_FRAME_US
) (
	input wire logic clk_i, // 125 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic rx_bit_i, // received pcm bit
	input wire logic rx_bit_en_i, // one-cycle strobe per received bit
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte enables
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	output logic ts16_bit_o, // extracted timeslot sixteen bit
	output logic ts16_en_o, // strobe marking a valid ts16_bit_o
	output logic red_alarm_o // red alarm level
);
	import efs_pkg::*;

	initial begin
		if (T8_FRAMES < 2 * `EFS_MF_FRAMES || T8_FRAMES > 128 || T400_FRAMES <= T8_FRAMES || T400_FRAMES > 4095 ||
			RED_FRAMES < 1 || RED_FRAMES > 1023) begin
			$error("efs_frame_sync: timer parameters out of range");
		end
	end

	localparam logic [6:0] T8_LAST = 7'(T8_FRAMES - 1);
	localparam logic [11:0] T400_LAST = 12'(T400_FRAMES - 1);
	localparam logic [9:0] RED_LAST = 10'(RED_FRAMES - 1);

	// one hunt step, shared by the main and the offline search
	function automatic efs_hunt_t hunt_step(efs_hunt_t s, logic fas, logic nfas, logic [7:0] pos);
		efs_hunt_t n;
		n = s;
		unique case (s)
			EFS_HUNT: if (fas) n = EFS_CHK_NFAS;
			EFS_CHK_NFAS: if (pos == 8'h07) n = nfas ? EFS_CHK_FAS : EFS_SKIP;
			EFS_SKIP: if (pos == 8'hFF) n = EFS_HUNT;
			EFS_CHK_FAS: if (pos == 8'h07) n = fas ? EFS_LOCK : EFS_HUNT;
			EFS_LOCK: n = EFS_LOCK;
			default: n = EFS_HUNT;
		endcase
		return n;
	endfunction

	// debounce state {out, last, count}
	function automatic logic [3:0] deb(logic [3:0] st, logic v, logic four);
		logic [1:0] c;
		logic o;
		c = (v == st[2]) ? ((st[1:0] == 2'h3) ? 2'h3 : st[1:0] + 2'h1) : 2'h0;
		o = (c >= (four ? 2'h3 : 2'h0)) ? v : st[3];
		return {o, v, c};
	endfunction

	logic [7:0] bit_cnt_reg, bit_cnt_next, sh_reg, sh_next, ocnt_reg, ocnt_next;
	efs_hunt_t hst_reg, hst_next, ost_reg, ost_next;
	logic oof_reg, oof_next, off_reg, off_next, mfu_reg, mfu_next, mf_run_reg, mf_run_next;
	logic first_reg, first_next, iw_reg, iw_next, smfu_reg, smfu_next, prev_nz_reg, prev_nz_next;
	logic red_reg, red_next, ts16_reg, ts16_next, ts16_en_reg, ts16_en_next;
	logic [1:0] fas_err_reg, fas_err_next, nfas_err_reg, nfas_err_next, e_reg, e_next;
	logic [2:0] crc_sh_reg, crc_sh_next;
	logic [3:0] frm_reg, frm_next, since_reg, since_next, crc_reg, crc_next, smf_cnt_reg, smf_cnt_next;
	logic [3:0] rai_reg, rai_next, rsm_reg, rsm_next;
	logic [4:0] msh_reg, msh_next;
	logic [6:0] t8_reg, t8_next;
	logic [11:0] t400_reg, t400_next;
	logic [9:0] red_cnt_reg, red_cnt_next;
	logic [14:0] sa_sh_reg, sa_sh_next;
	logic [19:0] sa_reg, sa_next;
	logic [5:0] ctrl_reg, ctrl_next, evt_reg, evt_next, ev_set;
	logic [7:0] stat, stat_prev_reg;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [7:0] w;
	logic fas, nfas, at7, eof, si, hit, lost;
	logic [3:0] nib;

	assign w = {sh_reg[6:0], rx_bit_i};
	assign fas = (w[6:0] == `EFS_FAS_WORD);
	assign nfas = w[6];
	assign si = w[7];
	assign at7 = (bit_cnt_reg == 8'h07);
	assign eof = (bit_cnt_reg == 8'hFF);
	assign hit = ({msh_reg, si} == `EFS_MFAS_SEQ);
	assign nib = {sh_reg[2:0], rx_bit_i};
	assign stat = {rsm_reg[3], rai_reg[3], red_reg, smfu_reg, iw_reg, off_reg, mfu_reg, oof_reg};

	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		sh_next = sh_reg;
		hst_next = hst_reg;
		ost_next = ost_reg;
		ocnt_next = ocnt_reg;
		oof_next = oof_reg;
		off_next = off_reg;
		mfu_next = mfu_reg;
		mf_run_next = mf_run_reg;
		first_next = first_reg;
		iw_next = iw_reg;
		smfu_next = smfu_reg;
		prev_nz_next = prev_nz_reg;
		red_next = red_reg;
		red_cnt_next = red_cnt_reg;
		fas_err_next = fas_err_reg;
		nfas_err_next = nfas_err_reg;
		e_next = e_reg;
		crc_sh_next = crc_sh_reg;
		crc_next = crc_reg;
		frm_next = frm_reg;
		since_next = since_reg;
		smf_cnt_next = smf_cnt_reg;
		rai_next = rai_reg;
		rsm_next = rsm_reg;
		msh_next = msh_reg;
		t8_next = t8_reg;
		t400_next = t400_reg;
		sa_sh_next = sa_sh_reg;
		sa_next = sa_reg;
		ts16_next = ts16_reg;
		ts16_en_next = 1'b0;
		ev_set = 6'h00;
		lost = 1'b0;
		if (rx_bit_en_i) begin
			sh_next = w;
			bit_cnt_next = bit_cnt_reg + 8'h01;
			if (eof) begin
				frm_next = frm_reg + 4'h1;
				// out-of-frame persistence is measured in frame periods
				red_cnt_next = (oof_reg && red_cnt_reg != RED_LAST) ? red_cnt_reg + 10'h001 : 10'h000;
				red_next = oof_reg && (red_cnt_reg == RED_LAST || red_reg);
				ev_set[`EFS_EVT_FRM] = !oof_reg;
				if (!smfu_reg) begin
					smf_cnt_next = smf_cnt_reg + 4'h1;
					ev_set[`EFS_EVT_SIGMF] = (smf_cnt_reg == 4'hF);
				end
				if (mfu_reg) begin
					since_next = since_reg + 4'h1;
				end
				if (mf_run_reg && mfu_reg && !iw_reg && !oof_reg) begin
					if (t8_reg != T8_LAST) begin
						t8_next = t8_reg + 7'h01;
					end else if (!off_reg) begin
						off_next = 1'b1;
						ost_next = EFS_HUNT;
					end
					t400_next = t400_reg + 12'h001;
					if (t400_reg == T400_LAST) begin
						iw_next = 1'b1;
						off_next = 1'b0;
					end
				end
			end
			if (oof_reg) begin
				hst_next = hunt_step(hst_reg, fas, nfas, bit_cnt_reg);
				if (hst_reg == EFS_HUNT && fas) begin
					bit_cnt_next = 8'h08;
				end
				if (hst_next == EFS_LOCK) begin
					oof_next = 1'b0;
					// red alarm drops with the regained frame, before any ts16 output starts
					red_next = 1'b0;
					red_cnt_next = 10'h000;
					frm_next = 4'h0;
					fas_err_next = 2'h0;
					nfas_err_next = 2'h0;
					mf_run_next = ctrl_reg[`EFS_CTRL_CRC_MULTIFRAME_ENABLE];
					mfu_next = 1'b1;
					t8_next = 7'h00;
					t400_next = 12'h000;
					first_next = 1'b0;
				end
			end else begin
				// in sync: the frame marker sits at the last bit of timeslot zero
				if (at7) begin
					if (!frm_reg[0]) begin
						fas_err_next = fas ? 2'h0 : fas_err_reg + 2'h1;
					end else begin
						nfas_err_next = nfas ? 2'h0 : nfas_err_reg + 2'h1;
					end
					lost = (fas_err_next == `EFS_LOSS_CNT) ||
						(ctrl_reg[`EFS_CTRL_NFASL] && nfas_err_next == `EFS_LOSS_CNT);
				end
				if (lost) begin
					oof_next = 1'b1;
					hst_next = EFS_HUNT;
					mfu_next = 1'b1;
					mf_run_next = 1'b0;
					off_next = 1'b0;
					iw_next = 1'b0;
					smfu_next = 1'b1;
				end else begin
					if (at7 && frm_reg[0]) begin
						msh_next = {msh_reg[3:0], si};
						rai_next = deb(rai_reg, w[5], ctrl_reg[`EFS_CTRL_DEB4]);
					end
					if (at7 && mfu_reg && frm_reg[0] && hit && mf_run_reg &&
						(!iw_reg || ctrl_reg[`EFS_CTRL_IWSRCH])) begin
						if (first_reg && since_reg == 4'h0) begin
							mfu_next = 1'b0;
							off_next = 1'b0;
							iw_next = 1'b0;
							first_next = 1'b0;
							frm_next = 4'hB;
						end else begin
							// a later sequence restarts the spacing check from itself
							first_next = 1'b1;
							since_next = 4'h0;
						end
					end
					if (at7 && !mfu_reg) begin
						if (!frm_reg[0]) begin
							crc_sh_next = {crc_sh_reg[1:0], si};
							if (frm_reg[2:0] == 3'h6) begin
								crc_next = {crc_sh_reg, si};
							end
						end else begin
							sa_sh_next = {sa_sh_reg[9:0], w[4:0]};
							if (frm_reg == 4'hB && !hit) begin
								ev_set[`EFS_EVT_MFERR] = 1'b1;
							end
							if (frm_reg == 4'hD) begin
								e_next[1] = si;
							end
							if (frm_reg == 4'hF) begin
								e_next[0] = si;
							end
							if (frm_reg[2:0] == 3'h7) begin
								sa_next = {sa_sh_reg, w[4:0]};
								ev_set[`EFS_EVT_SMF] = 1'b1;
								ev_set[`EFS_EVT_MF] = frm_reg[3];
							end
						end
					end
					if (bit_cnt_reg == 8'h83) begin
						prev_nz_next = (nib != 4'h0);
						if (smfu_reg) begin
							if (ctrl_reg[`EFS_CTRL_SIGNALLING_MULTIFRAME_ENABLE] && nib == 4'h0 && prev_nz_reg) begin
								smfu_next = 1'b0;
								smf_cnt_next = 4'h0;
							end
						end else if (smf_cnt_reg == 4'h0 && nib != 4'h0) begin
							smfu_next = 1'b1;
						end
					end
					if (bit_cnt_reg == 8'h85 && !smfu_reg && smf_cnt_reg == 4'h0) begin
						rsm_next = deb(rsm_reg, rx_bit_i, ctrl_reg[`EFS_CTRL_DEB4]);
					end
					ts16_next = rx_bit_i;
					ts16_en_next = (bit_cnt_reg[7:3] == 5'h10);
				end
				// offline hunt runs beside the held alignment and takes over once it locks
				if (off_next && off_reg) begin
					ost_next = hunt_step(ost_reg, fas, nfas, ocnt_reg);
					ocnt_next = (ost_reg == EFS_HUNT && fas) ? 8'h08 : ocnt_reg + 8'h01;
					if (ost_next == EFS_LOCK) begin
						ost_next = EFS_HUNT;
						off_next = 1'b0;
						bit_cnt_next = 8'h08;
						frm_next = 4'h0;
						fas_err_next = 2'h0;
						nfas_err_next = 2'h0;
						t8_next = 7'h00;
						first_next = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_reg[`EFS_CTRL_UNFR]) begin
			bit_cnt_reg <= 8'h00;
			sh_reg <= 8'h00;
			hst_reg <= EFS_HUNT;
			ost_reg <= EFS_HUNT;
			ocnt_reg <= 8'h00;
			oof_reg <= 1'b1;
			off_reg <= 1'b0;
			mfu_reg <= 1'b1;
			mf_run_reg <= 1'b0;
			first_reg <= 1'b0;
			iw_reg <= 1'b0;
			smfu_reg <= 1'b1;
			prev_nz_reg <= 1'b0;
			red_reg <= 1'b0;
			red_cnt_reg <= 10'h000;
			fas_err_reg <= 2'h0;
			nfas_err_reg <= 2'h0;
			e_reg <= 2'h3;
			crc_sh_reg <= 3'h0;
			crc_reg <= 4'h0;
			frm_reg <= 4'h0;
			since_reg <= 4'h0;
			smf_cnt_reg <= 4'h0;
			rai_reg <= 4'h0;
			rsm_reg <= 4'h0;
			msh_reg <= 5'h00;
			t8_reg <= 7'h00;
			t400_reg <= 12'h000;
			sa_sh_reg <= 15'h0000;
			sa_reg <= 20'h00000;
			ts16_reg <= 1'b0;
			ts16_en_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			sh_reg <= sh_next;
			hst_reg <= hst_next;
			ost_reg <= ost_next;
			ocnt_reg <= ocnt_next;
			oof_reg <= oof_next;
			off_reg <= off_next;
			mfu_reg <= mfu_next;
			mf_run_reg <= mf_run_next;
			first_reg <= first_next;
			iw_reg <= iw_next;
			smfu_reg <= smfu_next;
			prev_nz_reg <= prev_nz_next;
			red_reg <= red_next;
			red_cnt_reg <= red_cnt_next;
			fas_err_reg <= fas_err_next;
			nfas_err_reg <= nfas_err_next;
			e_reg <= e_next;
			crc_sh_reg <= crc_sh_next;
			crc_reg <= crc_next;
			frm_reg <= frm_next;
			since_reg <= since_next;
			smf_cnt_reg <= smf_cnt_next;
			rai_reg <= rai_next;
			rsm_reg <= rsm_next;
			msh_reg <= msh_next;
			t8_reg <= t8_next;
			t400_reg <= t400_next;
			sa_sh_reg <= sa_sh_next;
			sa_reg <= sa_next;
			ts16_reg <= ts16_next;
			ts16_en_reg <= ts16_en_next;
		end
	end

	// wishbone slave: ack one cycle after the request, writes land on the acked edge
	always_comb begin
		ctrl_next = ctrl_reg;
		evt_next = evt_reg;
		ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
		dat_next = dat_reg;
		if (wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `EFS_ADR_CTRL) begin
				ctrl_next = wb_dat_i[5:0];
			end
			if (wb_adr_i == `EFS_ADR_EVT) begin
				evt_next = evt_reg & ~wb_dat_i[5:0];
			end
		end
		// a new event wins over a clear in the same cycle
		evt_next = evt_next | ev_set;
		evt_next[`EFS_EVT_STCHG] = evt_next[`EFS_EVT_STCHG] | (stat != stat_prev_reg);
		if (ack_next) begin
			unique case (wb_adr_i)
				`EFS_ADR_CTRL: dat_next = {26'h0000000, ctrl_reg};
				`EFS_ADR_STAT: dat_next = {24'h000000, stat};
				`EFS_ADR_EVT: dat_next = {26'h0000000, evt_reg};
				`EFS_ADR_OVH: dat_next = {26'h0000000, e_reg, crc_reg};
				`EFS_ADR_NAT: dat_next = {12'h000, sa_reg};
				default: dat_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= `EFS_CTRL_RST;
			evt_reg <= 6'h00;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			stat_prev_reg <= `EFS_STAT_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			evt_reg <= evt_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			stat_prev_reg <= stat;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign ts16_bit_o = ts16_reg;
	assign ts16_en_o = ts16_en_reg;
	assign red_alarm_o = red_reg;
endmodule

// ==== verilog/efs_map.svh ====
// register map, field positions, reset values and frame timing for the e1 frame sync block
`ifndef EFS_MAP_SVH
`define EFS_MAP_SVH

`define EFS_ADR_CTRL 8'h00
`define EFS_ADR_STAT 8'h04
`define EFS_ADR_EVT 8'h08
`define EFS_ADR_OVH 8'h0C
`define EFS_ADR_NAT 8'h10

`define EFS_CTRL_UNFR 0
`define EFS_CTRL_CRC_MULTIFRAME_ENABLE 1
`define EFS_CTRL_SIGNALLING_MULTIFRAME_ENABLE 2
`define EFS_CTRL_IWSRCH 3
`define EFS_CTRL_NFASL 4
`define EFS_CTRL_DEB4 5
`define EFS_CTRL_RST 6'h02

`define EFS_EVT_MFERR 0
`define EFS_EVT_FRM 1
`define EFS_EVT_SMF 2
`define EFS_EVT_MF 3
`define EFS_EVT_SIGMF 4
`define EFS_EVT_STCHG 5

`define EFS_STAT_RST 8'h13

`define EFS_FAS_WORD 7'h1B
`define EFS_MFAS_SEQ 6'h0B
`define EFS_LOSS_CNT 2'h3
`define EFS_FRAME_BITS 9'h100
`define EFS_FRAME_US 125
`define EFS_T8_MS 8
`define EFS_T400_MS 400
`define EFS_RED_MS 100
`define EFS_MF_STEP_MS 2
`define EFS_MF_FRAMES 16

`endif

// ==== verilog/efs_pkg.sv ====
// shared types for the e1 frame sync block
package efs_pkg;
	typedef enum logic [2:0] {
		EFS_HUNT = 3'h0,
		EFS_CHK_NFAS = 3'h1,
		EFS_SKIP = 3'h2,
		EFS_CHK_FAS = 3'h3,
		EFS_LOCK = 3'h4
	} efs_hunt_t;
endpackage
